// file: logic/seq_pkg.sv
// Constants shared by the measurement cycle sequencer and its dividers.
// Assumes a 10 MHz pclk and an APB master with 32-bit data.
//
// Functional notes
// (R1) Period nine resets every decade counting unit of the chain.
// (R2) Period zero presets the harmonic generator when highest band selected.
// (R3) Period one issues the offset enable command that presets the chain.
// (R4) Period two sets the gate generator; command periods last 10 us.
// (R5) Period three resets the latch flop and routes the clock to the gate.
// (R6) Period four opens the gate, which holds the sequencer meanwhile.
// (R7) Period five loads the decade contents into the display latches.
// (R8) Periods six and seven give one print strobe lasting 20 us.
// (R9) Period eight runs the display timer, which holds the sequencer.
// (R10) Sequencer steps on 100 kHz pulses from decade dividers of 10 MHz.
// (R11) A 2.5 MHz pulse train clocks the display multiplexer.
// (R12) BCD period code feeds two one-of-four decoders plus two extra lines.
// (R13) Decoder outputs are blanked while the period counter switches.
// (R14) An outside unit may hold the sequencer through an inhibit input.
// (R15) Gate is whole clock cycles from a 1 MHz programmable divider.
// (R16) Divider control 110, 001, 101, 011 selects 10^3 up to 10^6.
// (R17) Prescaled band stretches the gate fourfold via 2.5 MHz clocking.
// (R18) Each divider output fall gives one short clock-aligned edge pulse.
// (R19) Display period spans 60 ms to 40 s in ten decade steps; the code times nine steps.
// (R20) Nine presets display decade, seven clears it, eight waits for nine.
// (R21) Hold keeps the display decade cleared, parking the sequencer in eight.
// (R22) Fast jumper skips the display timer, leaving a 10 us period.
// (R23) Advance only on an uninhibited pulse; eight is followed by nine.
`default_nettype none

package seq_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ      = 10_000_000;
   localparam int unsigned GATE_REF_HZ = 1_000_000;
   localparam int unsigned SEQ_HZ      = 100_000;
   localparam int unsigned MUX_HZ      = 2_500_000;
   localparam int unsigned CMD_NS      = 10_000;
   localparam int unsigned PRINT_NS    = 20_000;
   localparam int unsigned DIV_REF     = CLK_HZ / GATE_REF_HZ;
   localparam int unsigned DIV_SEQ     = GATE_REF_HZ / SEQ_HZ;
   localparam int unsigned DIV_MUX     = CLK_HZ / MUX_HZ;
   localparam int unsigned CMD_CYC     = CMD_NS / (1_000_000_000 / CLK_HZ);
   localparam int unsigned PRINT_CYC   = PRINT_NS / (1_000_000_000 / CLK_HZ);
   localparam int unsigned DISP_MIN_MS = 60;
   localparam int unsigned DISP_MAX_MS = 40_000;

   // ----------------------------------------------------------------
   // Period codes
   // ----------------------------------------------------------------
   localparam logic [3:0] P_RESET  = 4'h9;
   localparam logic [3:0] P_HARM   = 4'h0;
   localparam logic [3:0] P_OFFS   = 4'h1;
   localparam logic [3:0] P_GSET   = 4'h2;
   localparam logic [3:0] P_GEN    = 4'h3;
   localparam logic [3:0] P_GATE   = 4'h4;
   localparam logic [3:0] P_UPD    = 4'h5;
   localparam logic [3:0] P_PRINTA = 4'h6;
   localparam logic [3:0] P_PRINTB = 4'h7;
   localparam logic [3:0] P_DISP   = 4'h8;
   localparam logic [3:0] DEC_FULL = 4'h9;

   // ----------------------------------------------------------------
   // Divider control codes, bit0 in the lsb
   // ----------------------------------------------------------------
   localparam logic [2:0] DIVC_E3 = 3'h3;
   localparam logic [2:0] DIVC_E4 = 3'h4;
   localparam logic [2:0] DIVC_E5 = 3'h5;
   localparam logic [2:0] DIVC_E6 = 3'h6;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  A_CTRL   = 8'h00;
   localparam logic [7:0]  A_RATE   = 8'h04;
   localparam logic [7:0]  A_STAT   = 8'h08;
   localparam int unsigned F_DIVC   = 0;
   localparam int unsigned F_PRESC  = 3;
   localparam int unsigned F_HIGH   = 4;
   localparam int unsigned F_HOLD   = 5;
   localparam int unsigned F_FAST   = 6;
   localparam int unsigned F_GOPEN  = 4;
   localparam int unsigned F_LATCH  = 5;
   localparam int unsigned F_DRUN   = 6;
   localparam int unsigned F_DDEC   = 8;
   localparam logic [15:0] RATE_RST = 16'h03E8;

endpackage : seq_pkg

`default_nettype wire

// file: logic/pulse_divider.sv
// Counting divider giving one-cycle pulses at a fraction of its enable rate.
// Assumes enable and clear come from logic on the same clock.
`default_nettype none

module pulse_divider #(
   parameter int unsigned DIV = 10
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Control
   input  wire logic clr,
   input  wire logic en,
   // Pulse
   output logic      tick
);

   logic [7:0] cnt_ff;

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 8'h00;
      end else if (clr) begin
         cnt_ff <= 8'h00;
      end else if (tick) begin
         cnt_ff <= 8'h00;
      end else if (en) begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // Combinational so that chained dividers stay in phase
   assign tick = en && !clr && (cnt_ff == 8'(DIV - 1));

endmodule : pulse_divider

`default_nettype wire

// file: logic/measurement_cycle_sequencer.sv
// Measurement cycle sequencer: period counter, command decoder, gate and
// display timers, behind an APB register slave.
// Assumes a 10 MHz pclk; ext_inhibit arrives asynchronously from a pin.
//
// Design decisions made here: the APB interface to the registers and the address map.
`default_nettype none

module measurement_cycle_sequencer #(
   parameter int unsigned RATIO_E3      = 1_000,
   parameter int unsigned RATIO_E4      = 10_000,
   parameter int unsigned RATIO_E5      = 100_000,
   parameter int unsigned RATIO_E6      = 1_000_000,
   parameter int unsigned DISP_UNIT_CYC = 10_000
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Outside inhibit
   input  wire logic        ext_inhibit,
   // Commands to the counting chain
   output logic             counter_reset_cmd,
   output logic             harmonic_preset_cmd,
   output logic             offset_enable_cmd,
   output logic             gate_set_cmd,
   output logic             gate_enable_cmd,
   output logic             gate_period_cmd,
   output logic             data_update_cmd,
   output logic             print_strobe,
   output logic             display_period_cmd,
   // Timing
   output logic             seq_clk_pulse,
   output logic             mux_clk_pulse,
   output logic             gate_level,
   output logic             gate_edge_pulse
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [2:0]  div_ctl_ff;
   logic        prescaled_band_ff;
   logic        highest_band_ff;
   logic        hold_ff;
   logic        fast_ff;
   logic [15:0] disp_rate_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_rdata;
   logic        addr_ok;
   logic        wr_en;

   logic [3:0]  period_ff;
   logic        latch_ff;
   logic        gate_open_ff;
   logic        gate_route_ff;
   logic        disp_run_ff;
   logic [3:0]  decade_ff;

   assign wr_en   = psel && penable && pwrite;
   assign addr_ok = (paddr == seq_pkg::A_CTRL) ||
                    (paddr == seq_pkg::A_RATE) ||
                    (paddr == seq_pkg::A_STAT);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata  = prdata_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ctl_ff        <= seq_pkg::DIVC_E3;
         prescaled_band_ff <= 1'b0;
         highest_band_ff   <= 1'b0;
         hold_ff           <= 1'b0;
         fast_ff           <= 1'b0;
      end else if (wr_en && paddr == seq_pkg::A_CTRL) begin
         div_ctl_ff        <= pwdata[seq_pkg::F_DIVC +: 3];
         prescaled_band_ff <= pwdata[seq_pkg::F_PRESC];
         highest_band_ff   <= pwdata[seq_pkg::F_HIGH];
         hold_ff           <= pwdata[seq_pkg::F_HOLD];
         fast_ff           <= pwdata[seq_pkg::F_FAST];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp_rate_ff <= seq_pkg::RATE_RST;
      end else if (wr_en && paddr == seq_pkg::A_RATE) begin
         disp_rate_ff <= pwdata[15:0];
      end
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (paddr)
         seq_pkg::A_CTRL: begin
            nxt_rdata[seq_pkg::F_DIVC +: 3] = div_ctl_ff;
            nxt_rdata[seq_pkg::F_PRESC]     = prescaled_band_ff;
            nxt_rdata[seq_pkg::F_HIGH]      = highest_band_ff;
            nxt_rdata[seq_pkg::F_HOLD]      = hold_ff;
            nxt_rdata[seq_pkg::F_FAST]      = fast_ff;
         end
         seq_pkg::A_RATE: nxt_rdata[15:0] = disp_rate_ff;
         seq_pkg::A_STAT: begin
            nxt_rdata[3:0]               = period_ff;
            nxt_rdata[seq_pkg::F_GOPEN]  = gate_open_ff;
            nxt_rdata[seq_pkg::F_LATCH]  = latch_ff;
            nxt_rdata[seq_pkg::F_DRUN]   = disp_run_ff;
            nxt_rdata[seq_pkg::F_DDEC +: 4] = decade_ff;
         end
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup cycle, stable through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= nxt_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Outside inhibit synchroniser
   // ----------------------------------------------------------------
   logic inh_s1_ff;
   logic inh_s2_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inh_s1_ff <= 1'b0;
         inh_s2_ff <= 1'b0;
      end else begin
         inh_s1_ff <= ext_inhibit;
         inh_s2_ff <= inh_s1_ff;
      end
   end

   // ----------------------------------------------------------------
   // Time base dividers
   // ----------------------------------------------------------------
   logic ref_tick;
   logic seq_tick;
   logic mux_tick;
   logic gate_src_en;
   logic gate_tick;

   pulse_divider #(.DIV(seq_pkg::DIV_REF)) u_ref (
      .pclk(pclk), .presetn(presetn), .clr(1'b0), .en(1'b1),
      .tick(ref_tick)
   );

   pulse_divider #(.DIV(seq_pkg::DIV_SEQ)) u_seq (  // R10
      .pclk(pclk), .presetn(presetn), .clr(1'b0), .en(ref_tick),
      .tick(seq_tick)
   );

   pulse_divider #(.DIV(seq_pkg::DIV_MUX)) u_mux (  // R11
      .pclk(pclk), .presetn(presetn), .clr(1'b0), .en(1'b1),
      .tick(mux_tick)
   );

   // Prescaled band feeds the gate path at a quarter rate
   assign gate_src_en = gate_open_ff && gate_route_ff &&
                        (!prescaled_band_ff || mux_tick); // R17

   pulse_divider #(.DIV(seq_pkg::DIV_REF)) u_gref (  // R15
      .pclk(pclk), .presetn(presetn), .clr(!gate_open_ff),
      .en(gate_src_en), .tick(gate_tick)
   );

   logic seq_pulse_ff;
   logic mux_pulse_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_pulse_ff <= 1'b0;
         mux_pulse_ff <= 1'b0;
      end else begin
         seq_pulse_ff <= seq_tick;
         mux_pulse_ff <= mux_tick;
      end
   end

   assign seq_clk_pulse = seq_pulse_ff;
   assign mux_clk_pulse = mux_pulse_ff;

   // ----------------------------------------------------------------
   // Gate generator
   // ----------------------------------------------------------------
   logic [19:0] ratio;
   logic [19:0] gdiv_ff;
   logic        gdiv_wrap;
   logic        edge_ff;
   logic        seq_step;

   always_comb begin
      unique case (div_ctl_ff)  // R16
         seq_pkg::DIVC_E4: ratio = 20'(RATIO_E4);
         seq_pkg::DIVC_E5: ratio = 20'(RATIO_E5);
         seq_pkg::DIVC_E6: ratio = 20'(RATIO_E6);
         default:          ratio = 20'(RATIO_E3);
      endcase
   end

   assign gdiv_wrap = gate_tick && (gdiv_ff == ratio - 20'h00001);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gdiv_ff <= 20'h00000;
      end else if (!gate_open_ff) begin
         gdiv_ff <= 20'h00000;
      end else if (gdiv_wrap) begin
         gdiv_ff <= 20'h00000;
      end else if (gate_tick) begin
         gdiv_ff <= gdiv_ff + 20'h00001;
      end
   end

   // One clock wide, so gate edges sit exactly on pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_ff <= 1'b0;
      end else begin
         edge_ff <= gate_open_ff && gdiv_wrap;  // R18
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_route_ff <= 1'b0;
         gate_open_ff  <= 1'b0;
         latch_ff      <= 1'b1;
      end else if (period_ff == seq_pkg::P_GEN && !gate_open_ff) begin
         latch_ff      <= 1'b0;  // R5
         gate_route_ff <= 1'b1;  // R5
         gate_open_ff  <= seq_step;  // R6
      end else if (gdiv_wrap) begin
         gate_open_ff  <= 1'b0;  // R15
         gate_route_ff <= 1'b0;
         latch_ff      <= 1'b1;
      end
   end

   assign gate_level      = gate_open_ff;
   assign gate_edge_pulse = edge_ff;

   // ----------------------------------------------------------------
   // Display time generator
   // ----------------------------------------------------------------
   logic [15:0] rate_ms;
   logic [15:0] unit_ff;
   logic [15:0] step_ff;
   logic        unit_done;
   logic        step_done;
   logic        disp_inh;

   always_comb begin
      if (disp_rate_ff < 16'(seq_pkg::DISP_MIN_MS)) begin  // R19
         rate_ms = 16'(seq_pkg::DISP_MIN_MS);
      end else if (disp_rate_ff > 16'(seq_pkg::DISP_MAX_MS)) begin
         rate_ms = 16'(seq_pkg::DISP_MAX_MS);
      end else begin
         rate_ms = disp_rate_ff;
      end
   end

   // Unit is a tenth of a millisecond; nine decade steps of rate_ms units each
   assign unit_done = disp_run_ff &&
                      (unit_ff == 16'(DISP_UNIT_CYC / 10 - 1));
   assign step_done = unit_done && (step_ff == rate_ms - 16'h0001);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_ff <= 16'h0000;
         step_ff <= 16'h0000;
      end else if (!disp_run_ff) begin
         unit_ff <= 16'h0000;
         step_ff <= 16'h0000;
      end else if (unit_done) begin
         unit_ff <= 16'h0000;
         step_ff <= step_done ? 16'h0000 : step_ff + 16'h0001;
      end else begin
         unit_ff <= unit_ff + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         decade_ff <= seq_pkg::DEC_FULL;
      end else if (hold_ff) begin
         decade_ff <= 4'h0;  // R21
      end else if (period_ff == seq_pkg::P_RESET) begin
         decade_ff <= seq_pkg::DEC_FULL;  // R20
      end else if (period_ff == seq_pkg::P_PRINTB) begin
         decade_ff <= 4'h0;  // R20
      end else if (step_done && decade_ff != seq_pkg::DEC_FULL) begin
         decade_ff <= decade_ff + 4'h1;  // R19
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp_run_ff <= 1'b0;
      end else if (hold_ff || fast_ff) begin
         disp_run_ff <= 1'b0;  // R22
      end else if (period_ff == seq_pkg::P_DISP &&
                   decade_ff != seq_pkg::DEC_FULL) begin
         disp_run_ff <= !(step_done && decade_ff == 4'h8);  // R9
      end else begin
         disp_run_ff <= 1'b0;
      end
   end

   // Hold wins over the fast jumper
   assign disp_inh = (period_ff == seq_pkg::P_DISP) &&
                     (hold_ff ||
                      (!fast_ff && decade_ff != seq_pkg::DEC_FULL)); // R20

   // ----------------------------------------------------------------
   // Period counter and decoder
   // ----------------------------------------------------------------
   logic       inhibit;
   logic [9:0] dec;
   logic [9:0] cmd_ff;
   logic       print_ff;

   assign inhibit  = (period_ff == seq_pkg::P_GATE && !latch_ff) ||
                     disp_inh || inh_s2_ff;  // R14
   assign seq_step = seq_tick && !inhibit;  // R23

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_ff <= seq_pkg::P_RESET;
      end else if (seq_step) begin
         if (period_ff == seq_pkg::P_DISP) begin
            period_ff <= seq_pkg::P_RESET;  // R23
         end else if (period_ff == seq_pkg::P_RESET) begin
            period_ff <= seq_pkg::P_HARM;
         end else begin
            period_ff <= period_ff + 4'h1;  // R4
         end
      end
   end

   // Two one-of-four decoders chosen by bit 2, plus two lines from bit 3
   for (genvar i = 0; i < 8; i++) begin : g_dec
      assign dec[i] = !period_ff[3] && (period_ff[2] == 1'(i >> 2)) &&
                      (period_ff[1:0] == 2'(i));  // R12
   end
   assign dec[8] = period_ff[3] && !period_ff[0];  // R12
   assign dec[9] = period_ff[3] && period_ff[0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_ff <= 10'h000;
      end else if (seq_step) begin
         cmd_ff <= 10'h000;  // R13
      end else begin
         cmd_ff    <= dec;
         cmd_ff[0] <= dec[0] && highest_band_ff;  // R2
      end
   end

   // Spans both print periods without a gap at the changeover
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         print_ff <= 1'b0;
      end else begin
         print_ff <= dec[6] || dec[7];  // R8
      end
   end

   assign counter_reset_cmd   = cmd_ff[9];  // R1
   assign harmonic_preset_cmd = cmd_ff[0];
   assign offset_enable_cmd   = cmd_ff[1];  // R3
   assign gate_set_cmd        = cmd_ff[2];  // R4
   assign gate_enable_cmd     = cmd_ff[3];
   assign gate_period_cmd     = cmd_ff[4];
   assign data_update_cmd     = cmd_ff[5];  // R7
   assign display_period_cmd  = cmd_ff[8];
   assign print_strobe        = print_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   localparam int PRINT_LEN = seq_pkg::PRINT_CYC;
   logic [8:0] print_len_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         print_len_ff <= 9'h000;
      end else begin
         print_len_ff <= print_ff ? print_len_ff + 9'h001 : 9'h000;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_reset_in_nine;
      counter_reset_cmd |-> period_ff == seq_pkg::P_RESET;
   endproperty
   a_reset_in_nine: assert property (p_reset_in_nine)  // R1
      else $error("counter reset outside period nine");

   property p_harm_band;
      harmonic_preset_cmd |-> $past(highest_band_ff) && period_ff == 4'h0;
   endproperty
   a_harm_band: assert property (p_harm_band)  // R2
      else $error("harmonic preset without highest band");

   property p_blank;
      seq_step |=> cmd_ff == 10'h000;
   endproperty
   a_blank: assert property (p_blank)  // R13
      else $error("decoder not blanked at switch");

   property p_seq_rate;
      seq_clk_pulse |-> ##1 !seq_clk_pulse [*8] ##92 seq_clk_pulse;
   endproperty
   a_seq_rate: assert property (p_seq_rate)  // R10
      else $error("sequence pulse not every 100 cycles");

   property p_mux_rate;
      mux_clk_pulse |-> ##1 !mux_clk_pulse [*3] ##1 mux_clk_pulse;
   endproperty
   a_mux_rate: assert property (p_mux_rate)  // R11
      else $error("mux pulse not every 4 cycles");

   property p_print_len;
      $fell(print_strobe) |-> print_len_ff == 9'(PRINT_LEN);
   endproperty
   a_print_len: assert property (p_print_len)  // R8
      else $error("print strobe length wrong");

   property p_advance;
      period_ff != $past(period_ff) |-> $past(seq_step);
   endproperty
   a_advance: assert property (p_advance)  // R23
      else $error("period changed without clean pulse");

   property p_hold_park;
      hold_ff && period_ff == seq_pkg::P_DISP |=> period_ff == 4'h8;
   endproperty
   a_hold_park: assert property (p_hold_park)  // R21
      else $error("hold did not park in period eight");

   property p_gate_in_four;
      gate_level |-> period_ff == seq_pkg::P_GATE;
   endproperty
   a_gate_in_four: assert property (p_gate_in_four)  // R6
      else $error("gate open outside period four");

   property p_edge_single;
      gate_edge_pulse |=> !gate_edge_pulse ##1 !gate_level;
   endproperty
   a_edge_single: assert property (p_edge_single)  // R18
      else $error("edge pulse too long or gate not closed");

   c_print: cover property ($rose(print_strobe));
   c_gate_close: cover property ($fell(gate_level));
   c_cycle: cover property (period_ff == 4'h8 ##1 period_ff == 4'h9);
   c_harm: cover property (harmonic_preset_cmd);

endmodule : measurement_cycle_sequencer

`default_nettype wire

// file: bench/chain_model.sv
// Far-side model: front-panel unit that may hold the sequencer.
// Assumes it shares pclk with the sequencer.
`default_nettype none
module chain_model (
   // Clock and request
   input  wire logic pclk,
   input  wire logic inh_req,
   // To sequencer
   output logic      ext_inhibit
);
   timeunit 1ns;
   timeprecision 1ns;
   // Registered, so the pin moves only on the rising pclk edge the sequencer samples on
   always_ff @(posedge pclk) ext_inhibit <= inh_req;
endmodule : chain_model
`default_nettype wire

// file: bench/tb_top.sv
// Bench for the measurement cycle sequencer.
// Assumes chain_model stands in for the outside inhibit source.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, inh_req, ext_inh;
   logic pready, pslverr, seq_p, mux_p, er, gl, ge;
   logic gl_q = 1'b0;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, dv;
   logic [8:0] cmd;
   logic [8:0] cmd_q = 9'h000;
   int fail_count, n_tests, cyc, w_pr, w_of, t_seq, t_mux;
   int w_gt, w_dp, g_exp, g_tol, d_min;
   int exp_q[$];
   integer seed = 32'h93D56BE5;
   // Short gate ratios keep the run brief
   measurement_cycle_sequencer #(.RATIO_E3(5), .RATIO_E4(10),
      .RATIO_E5(20), .RATIO_E6(40), .DISP_UNIT_CYC(20)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_inhibit(ext_inh),
      .counter_reset_cmd(cmd[8]), .harmonic_preset_cmd(cmd[7]),
      .offset_enable_cmd(cmd[6]), .gate_set_cmd(cmd[5]),
      .gate_enable_cmd(cmd[4]), .gate_period_cmd(cmd[3]),
      .data_update_cmd(cmd[2]), .print_strobe(cmd[1]),
      .display_period_cmd(cmd[0]), .seq_clk_pulse(seq_p),
      .mux_clk_pulse(mux_p), .gate_level(gl), .gate_edge_pulse(ge));
   chain_model far (.pclk(pclk), .inh_req(inh_req), .ext_inhibit(ext_inh));
   initial begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic test_done;
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   // Entered just after a rising edge; leaves one edge after completion
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   task automatic drain;
      while (exp_q.size() != 0) @(posedge pclk);
   endtask : drain
   // Watcher: command order, widths and pulse rates
   always @(posedge pclk) if (presetn) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         test_done;
      end
      for (int i = 0; i < 9; i++) if (cmd[i] && !cmd_q[i])
         chk("cmd", exp_q.size() ? exp_q.pop_front() : 99, i);
      if (!cmd[1] && cmd_q[1]) chk("print", 200, w_pr);
      if (!cmd[6] && cmd_q[6]) chk("cmdlen", 99, w_of);
      if (!gl && gl_q) begin
         chk("gatelen", 1, w_gt <= g_exp && w_gt + g_tol >= g_exp);
         chk("gatedge", 1, ge);
      end
      if (!cmd[0] && cmd_q[0] && d_min != 0)
         chk("disp", 1, w_dp >= d_min && w_dp <= d_min + 110);
      w_pr = cmd[1] ? w_pr + 1 : 0;
      w_of = cmd[6] ? w_of + 1 : 0;
      w_gt = gl ? w_gt + 1 : 0;
      w_dp = cmd[0] ? w_dp + 1 : 0;
      if (seq_p) begin
         if (t_seq != 0) chk("seqclk", 100, t_seq);
         t_seq = 1;
      end else if (t_seq != 0) t_seq++;
      if (mux_p) begin
         if (t_mux != 0) chk("muxclk", 4, t_mux);
         t_mux = 1;
      end else if (t_mux != 0) t_mux++;
      cmd_q <= cmd;
      gl_q <= gl;
   end
   initial begin
      {psel, penable, pwrite, inh_req, presetn} = 0;
      paddr = 0;
      pwdata = 0;
      exp_q = {8};
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, 8'h00, 0);
      chk("ctrl", 32'h03, rd);
      apb(0, 8'h04, 0);
      chk("rate", 32'h3E8, rd);
      apb(0, 8'h0C, 0);
      chk("slverr", 1, er);
      dv = 3 + ($unsigned($random(seed)) % 4);
      // Gate is ten clocks per divider count: 5, 10, 20, 40 counts here
      g_exp = 50 << (dv - 3);
      apb(1, 8'h00, 32'h50 | dv);
      exp_q = {exp_q, 7, 6, 5, 4, 3, 2, 1, 0};
      drain();
      // Prescaled band, highest band dropped
      apb(1, 8'h00, 32'h48 | dv);
      // Quarter-rate gate clock; its phase may shave up to three cycles
      g_exp = 200 << (dv - 3);
      g_tol = 3;
      exp_q = {8, 6, 5, 4, 3, 2, 1, 0};
      drain();
      apb(1, 8'h00, 32'h60);
      repeat (500) @(posedge pclk);
      apb(0, 8'h08, 0);
      chk("period", 8, rd & 32'hF);
      inh_req <= 1;
      // Let the inhibit pass its synchroniser before hold is dropped
      repeat (4) @(posedge pclk);
      apb(1, 8'h00, 32'h40);
      exp_q = {8};
      repeat (600) @(posedge pclk);
      chk("frozen", 1, exp_q.size());
      inh_req <= 0;
      drain();
      // Normal display timer at the clamped shortest rate
      apb(1, 8'h00, dv);
      apb(1, 8'h04, 0);
      g_tol = 0;
      g_exp = 50 << (dv - 3);
      d_min = 1080;
      exp_q = {6, 5, 4, 3, 2, 1, 0, 8};
      drain();
      test_done;
   end
endmodule : tb_top
`default_nettype wire
